// >>> rtl/led_gpio_strap_pin_control.sv
// shared lamp / general pin / strap pin control with interrupt output driver
//
// Notes on behaviour
// - with the lamp 0 enable bit set, the shared pin carries the lamp function.
// - with the lamp 0 enable bit clear, the general pin logic owns direction and value of the pin.
// - in lamp use the 3-bit lamp function field picks push-pull or open-drain/open-source drive.
// - in open-drain/open-source lamp use the active polarity comes from the host interface strap 0 caught at reset.
// - in general use software picks push-pull output, open-drain output or Schmitt input.
// - all strap levels are caught after the power-on hold time, once the power-on or external reset is released.
// - the caught host interface strap 0 level is the serial management mode hard-strap.
// - interrupt output polarity, source selection and driver type are set in the interrupt config register.
// - a low level on the external reset input resets the whole block.
// - an internal power-on reset brings the block up even with the external reset left open.
`timescale 1ns/10ps
module led_gpio_strap_pin_control
  import pin_ctrl_pkg::*;
(
  input  wire  logic                 clk,
  input  wire  logic                 resetn,
  input  wire  logic                 porN,
  input  wire  logic [ADDR_W-1:0]    regAddr,
  input  wire  logic [DATA_W-1:0]    regWrData,
  input  wire  logic                 regWrEn,
  input  wire  logic                 regRdEn,
  output logic       [DATA_W-1:0]    regRdData,
  input  wire  logic                 lampOn,
  input  wire  logic                 pinIn,
  output logic                       pinOut,
  output logic                       pinOe,
  input  wire  logic [STRAP_W-1:1]   otherStraps,
  output logic                       smiModeStrap,
  input  wire  logic [IRQ_SRC_W-1:0] irqSources,
  output logic                       irqOut,
  output logic                       irqOe
);

  // ==========================================================================
  // reset and strap unit
  reset_strap_if rs ();

  reset_strap_unit u_reset_strap (
    .clk       (clk),
    .resetn    (resetn),
    .porN      (porN),
    .strapPins ({otherStraps, pinIn}),
    .rs        (rs.producer)
  );

  // ==========================================================================
  // state
  typedef struct packed {
    logic                  lampEn;
    logic [LAMP_FUN_W-1:0] lampFun;
    logic                  gpioOpenDrain;
    logic                  gpioData;
    logic                  gpioDir;
    logic                  gpioIn;
    logic                  irqEn;
    logic                  irqPolHigh;
    logic                  irqPushPull;
    logic [IRQ_SRC_W-1:0]  irqSel;
    logic [DATA_W-1:0]     rdData;
    logic                  pinOut;
    logic                  pinOe;
    logic                  irqOut;
    logic                  irqOe;
  } ctrl_t;

  ctrl_t ctrl_reg;
  ctrl_t ctrl_next;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    hit = (addr == off);
  endfunction : hit

  // ==========================================================================
  // next state
  logic lampOpen;
  logic strapPol;
  logic irqActive;

  always_comb begin
    ctrl_next = ctrl_reg;
    lampOpen  = (ctrl_reg.lampFun != LAMP_FUN_PUSH_PULL);
    strapPol  = rs.straps[0];
    irqActive = ctrl_reg.irqEn & (|(irqSources & ctrl_reg.irqSel));

    // schmitt input sample; pins are synchronous to clk
    ctrl_next.gpioIn = pinIn;

    // register writes
    if (regWrEn) begin
      if (hit(regAddr, LAMP_CFG_OFF)) begin
        ctrl_next.lampEn  = regWrData[LAMP_EN_BIT];
        ctrl_next.lampFun = regWrData[LAMP_FUN_LSB +: LAMP_FUN_W];
      end
      if (hit(regAddr, GPIO_CFG_OFF)) begin
        ctrl_next.gpioOpenDrain = regWrData[GPIO_OD_BIT];
      end
      if (hit(regAddr, GPIO_DATA_DIR_OFF)) begin
        ctrl_next.gpioData = regWrData[GPIO_DATA_BIT];
        ctrl_next.gpioDir  = regWrData[GPIO_DIR_BIT];
      end
      if (hit(regAddr, IRQ_CFG_OFF)) begin
        ctrl_next.irqEn       = regWrData[IRQ_EN_BIT];
        ctrl_next.irqPolHigh  = regWrData[IRQ_POL_BIT];
        ctrl_next.irqPushPull = regWrData[IRQ_PP_BIT];
        ctrl_next.irqSel      = regWrData[IRQ_SEL_LSB +: IRQ_SRC_W];
      end
    end

    // register reads, answered in the next cycle only; unmapped reads give zero
    ctrl_next.rdData = RD_ZERO;
    if (regRdEn) begin
      if (hit(regAddr, LAMP_CFG_OFF)) begin
        ctrl_next.rdData[LAMP_EN_BIT]                 = ctrl_reg.lampEn;
        ctrl_next.rdData[LAMP_FUN_LSB +: LAMP_FUN_W]  = ctrl_reg.lampFun;
      end
      if (hit(regAddr, GPIO_CFG_OFF)) begin
        ctrl_next.rdData[GPIO_OD_BIT] = ctrl_reg.gpioOpenDrain;
      end
      if (hit(regAddr, GPIO_DATA_DIR_OFF)) begin
        ctrl_next.rdData[GPIO_DATA_BIT] = ctrl_reg.gpioData;
        ctrl_next.rdData[GPIO_DIR_BIT]  = ctrl_reg.gpioDir;
        ctrl_next.rdData[GPIO_IN_BIT]   = ctrl_reg.gpioIn;
      end
      if (hit(regAddr, IRQ_CFG_OFF)) begin
        ctrl_next.rdData[IRQ_EN_BIT]                = ctrl_reg.irqEn;
        ctrl_next.rdData[IRQ_POL_BIT]               = ctrl_reg.irqPolHigh;
        ctrl_next.rdData[IRQ_PP_BIT]                = ctrl_reg.irqPushPull;
        ctrl_next.rdData[IRQ_SEL_LSB +: IRQ_SRC_W]  = ctrl_reg.irqSel;
        ctrl_next.rdData[IRQ_STATE_BIT]             = irqActive;
      end
      if (hit(regAddr, STRAP_STS_OFF)) begin
        ctrl_next.rdData[STRAP_W-1:0]     = rs.straps;
        ctrl_next.rdData[STRAP_VALID_BIT] = rs.strapsValid;
      end
    end

    // shared pin driver
    if (ctrl_reg.lampEn) begin
      if (!lampOpen) begin
        // push-pull lamp sinks current: low lights it
        ctrl_next.pinOut = ~lampOn;
        ctrl_next.pinOe  = 1'b1;
      end else if (strapPol) begin
        // strap high: open-drain, pulls low while lit
        ctrl_next.pinOut = 1'b0;
        ctrl_next.pinOe  = lampOn;
      end else begin
        // strap low: open-source, drives high while lit
        ctrl_next.pinOut = 1'b1;
        ctrl_next.pinOe  = lampOn;
      end
    end else begin
      if (!ctrl_reg.gpioDir) begin
        ctrl_next.pinOut = 1'b0;
        ctrl_next.pinOe  = 1'b0;
      end else if (ctrl_reg.gpioOpenDrain) begin
        ctrl_next.pinOut = 1'b0;
        ctrl_next.pinOe  = ~ctrl_reg.gpioData;
      end else begin
        ctrl_next.pinOut = ctrl_reg.gpioData;
        ctrl_next.pinOe  = 1'b1;
      end
    end

    // interrupt pin driver
    if (ctrl_reg.irqPushPull) begin
      ctrl_next.irqOut = ctrl_reg.irqPolHigh ? irqActive : ~irqActive;
      ctrl_next.irqOe  = 1'b1;
    end else begin
      // open-drain can only pull low, so polarity does not apply
      ctrl_next.irqOut = 1'b0;
      ctrl_next.irqOe  = irqActive;
    end
  end

  // ==========================================================================
  // registers; pin drivers stay off in reset so the strap level is readable
  always_ff @(posedge clk or negedge rs.coreRstN) begin
    if (!rs.coreRstN) begin
      ctrl_reg.lampEn        <= LAMP_EN_RST;
      ctrl_reg.lampFun       <= LAMP_FUN_RST;
      ctrl_reg.gpioOpenDrain <= 1'b0;
      ctrl_reg.gpioData      <= 1'b0;
      ctrl_reg.gpioDir       <= 1'b0;
      ctrl_reg.gpioIn        <= 1'b0;
      ctrl_reg.irqEn         <= 1'b0;
      ctrl_reg.irqPolHigh    <= 1'b0;
      ctrl_reg.irqPushPull   <= 1'b0;
      ctrl_reg.irqSel        <= IRQ_SEL_RST;
      ctrl_reg.rdData        <= RD_ZERO;
      ctrl_reg.pinOut        <= 1'b0;
      ctrl_reg.pinOe         <= 1'b0;
      ctrl_reg.irqOut        <= 1'b0;
      ctrl_reg.irqOe         <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ==========================================================================
  // outputs
  assign regRdData    = ctrl_reg.rdData;
  assign pinOut       = ctrl_reg.pinOut;
  assign pinOe        = ctrl_reg.pinOe;
  assign irqOut       = ctrl_reg.irqOut;
  assign irqOe        = ctrl_reg.irqOe;
  assign smiModeStrap = rs.straps[0];

endmodule : led_gpio_strap_pin_control

// >>> rtl/pin_ctrl_pkg.sv
// package: register map, field layout, reset values and timing for the shared lamp/general pin block
package pin_ctrl_pkg;

  // ==========================================================================
  // register bus
  localparam int          ADDR_W             = 8;
  localparam int          DATA_W             = 32;
  localparam logic [7:0]  LAMP_CFG_OFF       = 8'h00;
  localparam logic [7:0]  GPIO_CFG_OFF       = 8'h04;
  localparam logic [7:0]  GPIO_DATA_DIR_OFF  = 8'h08;
  localparam logic [7:0]  IRQ_CFG_OFF        = 8'h0C;
  localparam logic [7:0]  STRAP_STS_OFF      = 8'h10;

  // ==========================================================================
  // field positions
  localparam int LAMP_EN_BIT      = 0;
  localparam int LAMP_FUN_LSB     = 8;
  localparam int LAMP_FUN_W       = 3;
  localparam int GPIO_OD_BIT      = 0;
  localparam int GPIO_DATA_BIT    = 0;
  localparam int GPIO_DIR_BIT     = 8;
  localparam int GPIO_IN_BIT      = 16;
  localparam int IRQ_EN_BIT       = 0;
  localparam int IRQ_POL_BIT      = 4;
  localparam int IRQ_PP_BIT       = 8;
  localparam int IRQ_SEL_LSB      = 16;
  localparam int IRQ_SRC_W        = 8;
  localparam int IRQ_STATE_BIT    = 31;
  localparam int STRAP_VALID_BIT  = 31;
  localparam int STRAP_W          = 4;

  // ==========================================================================
  // reset values and encodings
  localparam logic                   LAMP_EN_RST        = 1'b0;
  localparam logic [LAMP_FUN_W-1:0]  LAMP_FUN_PUSH_PULL = 3'h0;
  localparam logic [LAMP_FUN_W-1:0]  LAMP_FUN_RST       = 3'h0;
  localparam logic [IRQ_SRC_W-1:0]   IRQ_SEL_RST        = 8'h00;
  localparam logic [DATA_W-1:0]      RD_ZERO            = 32'h0000_0000;

  // ==========================================================================
  // power-on hold time before straps are caught
  localparam int CLK_PERIOD_NS   = 10;
  localparam int POR_HOLD_NS     = 1000;
  localparam int POR_HOLD_CYCLES = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CNT_W      = $clog2(POR_HOLD_CYCLES + 1);

endpackage : pin_ctrl_pkg

// >>> rtl/reset_strap_if.sv
// interface: core reset and captured strap levels from the reset unit to the pin logic
`timescale 1ns/10ps
interface reset_strap_if
  import pin_ctrl_pkg::*;
;
  logic               coreRstN;
  logic [STRAP_W-1:0] straps;
  logic               strapsValid;

  modport producer (output coreRstN, output straps, output strapsValid);
  modport consumer (input coreRstN, input straps, input strapsValid);
endinterface : reset_strap_if

// >>> rtl/reset_strap_unit.sv
// reset sequencing and strap capture for the pin block
`timescale 1ns/10ps
module reset_strap_unit
  import pin_ctrl_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               porN,
  input  wire logic [STRAP_W-1:0] strapPins,
  reset_strap_if.producer         rs
);

  // ==========================================================================
  // state
  typedef enum logic [2:0] {
    HOLD    = 3'b001,
    CAPTURE = 3'b010,
    RUN     = 3'b100
  } phase_t;

  typedef struct packed {
    phase_t                phase;
    logic [HOLD_CNT_W-1:0] holdCnt;
    logic [STRAP_W-1:0]    straps;
    logic                  valid;
    logic                  coreRstN;
  } unit_t;

  localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(POR_HOLD_CYCLES - 1);

  unit_t unit_reg;
  unit_t unit_next;
  logic  rawRstN;

  // either source resets; the internal one lets the pin float unconnected
  assign rawRstN = resetn & porN;

  // ==========================================================================
  // sequencing
  always_comb begin
    unit_next = unit_reg;
    unique case (unit_reg.phase)
      HOLD: begin
        if (unit_reg.holdCnt == HOLD_LAST) begin
          unit_next.phase = CAPTURE;
        end else begin
          unit_next.holdCnt = unit_reg.holdCnt + HOLD_CNT_W'(1);
        end
      end
      // core still in reset here, so no pin driver fights the strap level
      CAPTURE: begin
        unit_next.straps   = strapPins;
        unit_next.valid    = 1'b1;
        unit_next.coreRstN = 1'b1;
        unit_next.phase    = RUN;
      end
      RUN: begin
        unit_next.phase = RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rawRstN) begin
    if (!rawRstN) begin
      unit_reg.phase    <= HOLD;
      unit_reg.holdCnt  <= '0;
      unit_reg.straps   <= '0;
      unit_reg.valid    <= 1'b0;
      unit_reg.coreRstN <= 1'b0;
    end else begin
      unit_reg <= unit_next;
    end
  end

  assign rs.coreRstN    = unit_reg.coreRstN;
  assign rs.straps      = unit_reg.straps;
  assign rs.strapsValid = unit_reg.valid;

endmodule : reset_strap_unit

// >>> tb/pin_ctrl_monitor.sv
// checker: port-level relations of the shared pin block
`timescale 1ns/10ps
module pin_ctrl_monitor
  import pin_ctrl_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 porN,
  input wire logic [ADDR_W-1:0]    regAddr,
  input wire logic [DATA_W-1:0]    regWrData,
  input wire logic                 regWrEn,
  input wire logic                 regRdEn,
  input wire logic [DATA_W-1:0]    regRdData,
  input wire logic                 lampOn,
  input wire logic                 pinIn,
  input wire logic                 pinOut,
  input wire logic                 pinOe,
  input wire logic [STRAP_W-1:1]   otherStraps,
  input wire logic                 smiModeStrap,
  input wire logic [IRQ_SRC_W-1:0] irqSources,
  input wire logic                 irqOut,
  input wire logic                 irqOe
);
  // ==========================================
  // helper: cycles since release, strap seen at capture edge
  logic [7:0] cnt;
  logic       strapSeen;
  always_ff @(posedge clk or negedge resetn or negedge porN) begin
    if (!resetn || !porN) begin
      cnt       <= 8'h00;
      strapSeen <= 1'b0;
    end else begin
      if (cnt != 8'hC8) cnt <= cnt + 8'h01;
      if (cnt == 8'h64) strapSeen <= pinIn;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !porN);
  sequence s_captured;
    cnt == 8'h6E;
  endsequence
  sequence s_settled;
    cnt >= 8'h69;
  endsequence
  // ==========================================
  a_rd_idle_zero: assert property (!$past(regRdEn) |-> regRdData == RD_ZERO) else $error("read data without read");
  a_hold_quiet: assert property (cnt < 8'h64 |-> !pinOe && !pinOut && !irqOe && !irqOut) else $error("pins driven in hold");
  a_smi_hold: assert property (cnt < 8'h64 |-> !smiModeStrap) else $error("mode strap set in hold");
  a_strap_capture: assert property (s_captured |-> smiModeStrap == strapSeen) else $error("strap not caught");
  a_strap_stable: assert property (s_settled |-> $stable(smiModeStrap)) else $error("strap moved");
  a_irq_od_low: assert property (!irqOe |-> !irqOut) else $error("irq value while released");
  a_irq_cause: assert property (s_settled ##0 $changed({irqOut, irqOe}) |->
    $past(regWrEn, 2) || $past(regWrEn, 3) || $past(irqSources) != $past(irqSources, 2)) else $error("irq moved alone");
  a_pin_cause: assert property (s_settled ##0 $changed({pinOut, pinOe}) |->
    $past(regWrEn, 2) || $past(regWrEn, 3) || $past(lampOn) != $past(lampOn, 2)) else $error("pin moved alone");
endmodule : pin_ctrl_monitor
bind led_gpio_strap_pin_control pin_ctrl_monitor mon (.clk, .resetn, .porN, .regAddr, .regWrData, .regWrEn,
  .regRdEn, .regRdData, .lampOn, .pinIn, .pinOut, .pinOe, .otherStraps, .smiModeStrap, .irqSources, .irqOut, .irqOe);

// >>> tb/pin_board_model.sv
// board side of the shared pin: pull-up, optional external driver
`timescale 1ns/10ps
module pin_board_model (
  input  wire logic pinOut,
  input  wire logic pinOe,
  input  wire logic extEn,
  input  wire logic extLvl,
  output logic      pinIn
);
  // released pin floats up; when enabled, the external driver sets the strap level instead
  assign pinIn = pinOe ? pinOut : (extEn ? extLvl : 1'b1);
endmodule : pin_board_model

// >>> tb/led_gpio_strap_pin_control_test.sv
// testbench: register tasks and pin/strap/irq scenarios
`timescale 1ns/10ps
module led_gpio_strap_pin_control_test
  import pin_ctrl_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, porN = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, lampOn = 1'b0;
  logic extEn = 1'b0, extLvl = 1'b0, pinIn, pinOut, pinOe, smiModeStrap, irqOut, irqOe;
  logic [ADDR_W-1:0]    regAddr = 8'h00;
  logic [DATA_W-1:0]    regWrData = 32'h0000_0000, regRdData;
  logic [STRAP_W-1:1]   otherStraps = 3'h5;
  logic [IRQ_SRC_W-1:0] irqSources = 8'h00;
  int error_cnt = 0, n_compared = 0;
  logic [31:0] icfg [6] = '{32'h0004_0111, 32'h0004_0111, 32'h0004_0101, 32'h0004_0001, 32'h0004_0001, 32'h0004_0110};
  logic [7:0]  isrc [6] = '{8'h04, 8'h0B, 8'h04, 8'h04, 8'h00, 8'h04};
  logic [1:0]  iexp [6] = '{2'h3, 2'h2, 2'h2, 2'h2, 2'h0, 2'h2};
  always #5 clk = ~clk;
  led_gpio_strap_pin_control uut (.clk(clk), .resetn(resetn), .porN(porN), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .lampOn(lampOn),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .otherStraps(otherStraps), .smiModeStrap(smiModeStrap),
    .irqSources(irqSources), .irqOut(irqOut), .irqOe(irqOe));
  pin_board_model board (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn), .extLvl(extLvl), .pinIn(pinIn));
  // ==========================================
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    regAddr <= a; regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 chk(regRdData, exp);
  endtask : rdchk
  task automatic lamp(input logic lit, input logic [1:0] exp);
    @(posedge clk);
    lampOn <= lit;
    step(2);
    chk({pinOe, pinOut}, exp);
  endtask : lamp
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // ==========================================
  // watchdog: whole run is a few hundred cycles
  initial begin
    #200_000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1; porN <= 1'b1;
    step(110);
    rdchk(STRAP_STS_OFF, 32'h8000_000B);
    chk(smiModeStrap, 1'b1);
    chk({pinOe, pinOut, irqOe, irqOut}, 4'h0);
    @(posedge clk);
    otherStraps <= 3'h2; extEn <= 1'b1; extLvl <= 1'b0;
    rdchk(STRAP_STS_OFF, 32'h8000_000B);
    chk(smiModeStrap, 1'b1);
    rdchk(GPIO_DATA_DIR_OFF, 32'h0000_0000);
    extLvl <= 1'b1;
    rdchk(GPIO_DATA_DIR_OFF, 32'h0001_0000);
    extEn <= 1'b0;
    // unmapped place and read-only strap status
    wr(8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'h0000_0000);
    wr(STRAP_STS_OFF, 32'h0000_0000);
    rdchk(STRAP_STS_OFF, 32'h8000_000B);
    wr(LAMP_CFG_OFF, 32'h0000_0001);
    for (int lit = 0; lit < 2; lit++) lamp(lit[0], {1'b1, ~lit[0]});
    for (int f = 1; f < 8; f++) begin
      wr(LAMP_CFG_OFF, (32'(f) << LAMP_FUN_LSB) | 32'h0000_0001);
      for (int lit = 0; lit < 2; lit++) lamp(lit[0], {lit[0], 1'b0});
    end
    wr(LAMP_CFG_OFF, 32'h0000_0000);
    wr(GPIO_DATA_DIR_OFF, 32'h0000_0101);
    step(2);
    chk({pinOe, pinOut}, 2'h3);
    wr(GPIO_CFG_OFF, 32'h0000_0001);
    step(2);
    chk({pinOe, pinOut}, 2'h0);
    wr(GPIO_DATA_DIR_OFF, 32'h0000_0100);
    step(2);
    chk({pinOe, pinOut}, 2'h2);
    rdchk(GPIO_DATA_DIR_OFF, 32'h0000_0100);
    for (int i = 0; i < 6; i++) begin
      wr(IRQ_CFG_OFF, icfg[i]);
      irqSources <= isrc[i];
      step(2);
      chk({irqOe, irqOut}, iexp[i]);
      if (i == 0) rdchk(IRQ_CFG_OFF, 32'h8004_0111);
    end
    // external reset with the strap pin held low
    @(posedge clk);
    resetn <= 1'b0; extEn <= 1'b1; extLvl <= 1'b0;
    step(2);
    chk({pinOe, pinOut, irqOe, irqOut, smiModeStrap}, 5'h00);
    chk(regRdData, RD_ZERO);
    resetn <= 1'b1;
    step(110);
    chk(smiModeStrap, 1'b0);
    rdchk(STRAP_STS_OFF, 32'h8000_0004);
    rdchk(LAMP_CFG_OFF, 32'h0000_0000);
    extEn <= 1'b0;
    wr(LAMP_CFG_OFF, 32'h0000_0101);
    lamp(1'b1, 2'h3);
    lamp(1'b0, 2'h1);
    // internal power-on reset alone
    porN <= 1'b0;
    step(2);
    chk({pinOe, pinOut, irqOe, irqOut}, 4'h0);
    porN <= 1'b1;
    step(110);
    chk(smiModeStrap, 1'b1);
    rdchk(STRAP_STS_OFF, 32'h8000_0005);
    conclude();
  end
endmodule : led_gpio_strap_pin_control_test
